// ===== common/flsm_pkg.sv
// constants and types for the fiber link status monitor
// How it works
// - remote status bits latch until reset issued
// - unmarked receive interrupt sets bit 0
// - receive interrupt without end-of-frame sets bit 1
// - crc or framing error sets bit 2
// - receive fifo overrun sets bit 3
// - length mismatch sets format bit 4
// - transmit fifo underrun sets bit 5
// - two ticks without message set bit 6
// - remote bit 8 on two silent ticks
// - loopback mismatch sets bit 7, reset only
// - gain data while memory busy sets bit 8
// - feedback multiplexed data failure sets bit 9
// - remote bit 9 on command or feedback failure
// - image request without matching image sets bit 10
// - no valid image header sets bit 11
// - incompatible remote hardware sets bit 12
// - keep retrying download after any failure
// - 16-bit wrapping received message count
// - count messages with crc errors
// - count messages with format errors
// - two consecutive errors give fault, drive stops
package flsm_pkg;
	localparam int unsigned ADDR_W = 11;
	localparam int unsigned DATA_W = 16;
	localparam logic [10:0] ADDR_LOC_STAT_A  = 11'h050;
	localparam logic [10:0] ADDR_RX_CNT_A    = 11'h051;
	localparam logic [10:0] ADDR_CRC_CNT_A   = 11'h052;
	localparam logic [10:0] ADDR_FMT_CNT_A   = 11'h053;
	localparam logic [10:0] ADDR_REM_STAT_A  = 11'h054;
	localparam logic [10:0] ADDR_LOC_STAT_B  = 11'h438;
	localparam logic [10:0] ADDR_RX_CNT_B    = 11'h439;
	localparam logic [10:0] ADDR_CRC_CNT_B   = 11'h43A;
	localparam logic [10:0] ADDR_FMT_CNT_B   = 11'h43B;
	localparam logic [10:0] ADDR_REM_STAT_B  = 11'h43C;
	localparam int BIT_RX_UNMARKED  = 0;
	localparam int BIT_NO_EOF       = 1;
	localparam int BIT_CRC_FRAME    = 2;
	localparam int BIT_OVERRUN      = 3;
	localparam int BIT_FORMAT       = 4;
	localparam int BIT_TX_UNDERRUN  = 5;
	localparam int BIT_SYNC_LOSS    = 6;
	localparam int BIT_LOOPBACK     = 7;
	localparam int BIT_MISSED_GAIN  = 8;
	localparam int BIT_MUX_VERIFY   = 9;
	localparam int BIT_NO_OS_IMAGE  = 10;
	localparam int BIT_BAD_OS_HDR   = 11;
	localparam int BIT_HW_INCOMPAT  = 12;
	localparam int BIT_REM_SYNC     = 8;
	localparam int BIT_REM_MUX      = 9;
	localparam logic [15:0] STAT_RESET  = 16'h0000;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] COUNT_STEP  = 16'h0001;
	localparam logic [15:0] READ_ZERO   = 16'h0000;
	localparam logic [1:0]  TICK_SILENT_LIMIT = 2'h2;
	localparam logic [1:0]  COMM_ERR_LIMIT    = 2'h2;
	typedef enum logic [1:0] {
		LB_START,
		LB_WAIT,
		LB_DONE
	} flsm_lb_e;
endpackage

// ===== hdl/flsm_monitor.sv
// status registers and message counters for both fiber link ports
`timescale 1ns/1ps
`default_nettype none
module flsm_monitor
	import flsm_pkg::*;
#(
	parameter int unsigned LEN_W = 8
) (
	// clock and reset
	input  wire logic                   clk_in,
	input  wire logic                   rst_n_in,
	// software resets, one-cycle pulses
	input  wire logic                   fault_reset_in,
	input  wire logic                   warning_reset_in,
	// serial controller receive events, index 0 is port a
	input  wire logic [1:0]             rx_irq_in,
	input  wire logic [1:0]             rx_marked_in,
	input  wire logic [1:0]             rx_eof_in,
	input  wire logic [1:0]             rx_crc_err_in,
	input  wire logic [1:0]             rx_frame_err_in,
	input  wire logic [1:0][LEN_W-1:0]  rx_len_actual_in,
	input  wire logic [1:0][LEN_W-1:0]  rx_len_field_in,
	input  wire logic [1:0]             rx_overrun_in,
	input  wire logic [1:0]             tx_underrun_in,
	// link timing
	input  wire logic [1:0]             comm_cycle_tick_in,
	// loopback test
	input  wire logic [1:0]             lb_done_in,
	input  wire logic [1:0][15:0]       lb_tx_word_in,
	input  wire logic [1:0][15:0]       lb_rx_word_in,
	// gain and multiplexed data
	input  wire logic [1:0]             gain_rx_in,
	input  wire logic [1:0]             gain_mem_busy_in,
	input  wire logic [1:0]             mux_fb_fail_in,
	input  wire logic [1:0]             mux_cmd_fail_in,
	// operating system download
	input  wire logic [1:0]             os_req_in,
	input  wire logic [1:0]             os_match_in,
	input  wire logic [1:0]             os_hdr_invalid_in,
	input  wire logic [1:0]             os_hw_incompat_in,
	// status words reported by the remote power processor
	input  wire logic [1:0]             rem_stat_valid_in,
	input  wire logic [1:0][15:0]       rem_stat_word_in,
	// dual-port memory read side
	input  wire logic                   rd_en_in,
	input  wire logic [ADDR_W-1:0]      rd_addr_in,
	output var  logic [DATA_W-1:0]      rd_data_out,
	output var  logic                   rd_valid_out,
	// link control outputs
	output var  logic [1:0]             lb_start_out,
	output var  logic [1:0]             lb_active_out,
	output var  logic [1:0]             os_retry_out,
	output var  logic [1:0]             comm_fault_out,
	output var  logic [1:0]             drive_stop_out
);

	// set wins over clear
	function automatic logic [15:0] latch_bits(input logic [15:0] cur, input logic [15:0] set,
		input logic clr);
		latch_bits = set | (clr ? STAT_RESET : cur);
	endfunction

	logic [15:0] loc_stat_reg [2];
	logic [15:0] rem_stat_reg [2];
	logic [15:0] rx_cnt_reg   [2];
	logic [15:0] crc_cnt_reg  [2];
	logic [15:0] fmt_cnt_reg  [2];
	logic [1:0]  tick_cnt_reg [2];
	logic [1:0]  err_cnt_reg  [2];
	flsm_lb_e    lb_state_reg [2];
	logic [1:0]  os_retry_reg;
	logic [1:0]  comm_fault_reg;
	logic [1:0]  lb_start_reg;
	logic [1:0]  lb_active_reg;
	logic [15:0] rd_data_reg;
	logic        rd_valid_reg;

	wire clr_stat = fault_reset_in | warning_reset_in;

	genvar p;
	generate
		for (p = 0; p < 2; p++) begin : g_port
			wire unmarked = rx_irq_in[p] & ~rx_marked_in[p];
			wire no_eof   = rx_irq_in[p] & ~rx_eof_in[p];
			wire crc_frm  = rx_irq_in[p] & (rx_crc_err_in[p] | rx_frame_err_in[p]);
			wire len_bad  = rx_irq_in[p] & (rx_len_actual_in[p] != rx_len_field_in[p]);
			wire silent   = comm_cycle_tick_in[p] & ~rx_irq_in[p]
				& (tick_cnt_reg[p] >= TICK_SILENT_LIMIT - 2'h1);
			wire lb_bad   = (lb_state_reg[p] == LB_WAIT) & lb_done_in[p]
				& (lb_tx_word_in[p] != lb_rx_word_in[p]);
			wire gain_miss = gain_rx_in[p] & gain_mem_busy_in[p];
			wire no_image  = os_req_in[p] & ~os_match_in[p];
			wire os_fail   = no_image | os_hdr_invalid_in[p] | os_hw_incompat_in[p];
			wire msg_err   = unmarked | no_eof | crc_frm | len_bad;
			wire any_err   = msg_err | silent;
			wire [1:0] err_step = (err_cnt_reg[p] == COMM_ERR_LIMIT) ? err_cnt_reg[p]
				: err_cnt_reg[p] + 2'h1;
			wire [1:0] err_next = any_err ? err_step
				: (rx_irq_in[p] ? 2'h0 : err_cnt_reg[p]);
			wire [1:0] tick_next = rx_irq_in[p] ? 2'h0
				: ((comm_cycle_tick_in[p] && tick_cnt_reg[p] != TICK_SILENT_LIMIT)
				? tick_cnt_reg[p] + 2'h1 : tick_cnt_reg[p]);

			logic [15:0] loc_set;
			logic [15:0] rem_set;
			always_comb begin
				loc_set = STAT_RESET;
				loc_set[BIT_RX_UNMARKED] = unmarked;
				loc_set[BIT_NO_EOF]      = no_eof;
				loc_set[BIT_CRC_FRAME]   = crc_frm;
				loc_set[BIT_OVERRUN]     = rx_overrun_in[p];
				loc_set[BIT_FORMAT]      = len_bad;
				loc_set[BIT_TX_UNDERRUN] = tx_underrun_in[p];
				loc_set[BIT_SYNC_LOSS]   = silent;
				loc_set[BIT_LOOPBACK]    = lb_bad;
				loc_set[BIT_MISSED_GAIN] = gain_miss;
				loc_set[BIT_MUX_VERIFY]  = mux_fb_fail_in[p];
				loc_set[BIT_NO_OS_IMAGE] = no_image;
				loc_set[BIT_BAD_OS_HDR]  = os_hdr_invalid_in[p];
				loc_set[BIT_HW_INCOMPAT] = os_hw_incompat_in[p];
				// remote word carries its own bits, including its address fault
				rem_set = rem_stat_valid_in[p] ? rem_stat_word_in[p] : STAT_RESET;
				rem_set[BIT_REM_SYNC] = rem_set[BIT_REM_SYNC] | silent;
				rem_set[BIT_REM_MUX]  = rem_set[BIT_REM_MUX]
					| mux_fb_fail_in[p] | mux_cmd_fail_in[p];
			end

			always_ff @(posedge clk_in) begin
				if (!rst_n_in) begin
					loc_stat_reg[p] <= STAT_RESET;
					rem_stat_reg[p] <= STAT_RESET;
				end else begin
					loc_stat_reg[p] <= latch_bits(loc_stat_reg[p], loc_set, clr_stat);
					rem_stat_reg[p] <= latch_bits(rem_stat_reg[p], rem_set, clr_stat);
				end
			end

			always_ff @(posedge clk_in) begin
				if (!rst_n_in) begin
					rx_cnt_reg[p]  <= COUNT_RESET;
					crc_cnt_reg[p] <= COUNT_RESET;
					fmt_cnt_reg[p] <= COUNT_RESET;
				end else begin
					if (rx_irq_in[p])
						rx_cnt_reg[p] <= rx_cnt_reg[p] + COUNT_STEP;
					if (rx_irq_in[p] && rx_crc_err_in[p])
						crc_cnt_reg[p] <= crc_cnt_reg[p] + COUNT_STEP;
					if (len_bad)
						fmt_cnt_reg[p] <= fmt_cnt_reg[p] + COUNT_STEP;
				end
			end

			always_ff @(posedge clk_in) begin
				if (!rst_n_in) begin
					tick_cnt_reg[p]   <= 2'h0;
					err_cnt_reg[p]    <= 2'h0;
					comm_fault_reg[p] <= 1'b0;
					os_retry_reg[p]   <= 1'b0;
				end else begin
					tick_cnt_reg[p] <= tick_next;
					err_cnt_reg[p]  <= fault_reset_in ? 2'h0 : err_next;
					if (any_err && err_step == COMM_ERR_LIMIT)
						comm_fault_reg[p] <= 1'b1;
					else if (fault_reset_in)
						comm_fault_reg[p] <= 1'b0;
					os_retry_reg[p] <= os_fail;
				end
			end

			// loopback runs once after every rst_n_in reset, then never again; the software resets do not restart it
			always_ff @(posedge clk_in) begin
				if (!rst_n_in) begin
					lb_state_reg[p] <= LB_START;
					lb_start_reg[p] <= 1'b0;
					lb_active_reg[p] <= 1'b1;
				end else begin
					lb_start_reg[p] <= (lb_state_reg[p] == LB_START);
					unique case (lb_state_reg[p])
						LB_START: lb_state_reg[p] <= LB_WAIT;
						LB_WAIT:  if (lb_done_in[p]) begin
							lb_state_reg[p] <= LB_DONE;
							lb_active_reg[p] <= 1'b0;
						end
						LB_DONE:  lb_state_reg[p] <= LB_DONE;
					endcase
				end
			end

		end
	endgenerate

	// read port decode
	wire [15:0] rd_word =
		(rd_addr_in == ADDR_LOC_STAT_A) ? loc_stat_reg[0] :
		(rd_addr_in == ADDR_RX_CNT_A)   ? rx_cnt_reg[0]   :
		(rd_addr_in == ADDR_CRC_CNT_A)  ? crc_cnt_reg[0]  :
		(rd_addr_in == ADDR_FMT_CNT_A)  ? fmt_cnt_reg[0]  :
		(rd_addr_in == ADDR_REM_STAT_A) ? rem_stat_reg[0] :
		(rd_addr_in == ADDR_LOC_STAT_B) ? loc_stat_reg[1] :
		(rd_addr_in == ADDR_RX_CNT_B)   ? rx_cnt_reg[1]   :
		(rd_addr_in == ADDR_CRC_CNT_B)  ? crc_cnt_reg[1]  :
		(rd_addr_in == ADDR_FMT_CNT_B)  ? fmt_cnt_reg[1]  :
		(rd_addr_in == ADDR_REM_STAT_B) ? rem_stat_reg[1] : READ_ZERO;

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			rd_data_reg  <= READ_ZERO;
			rd_valid_reg <= 1'b0;
		end else begin
			rd_valid_reg <= rd_en_in;
			if (rd_en_in)
				rd_data_reg <= rd_word;
		end
	end

	// every output comes straight from a flop
	assign rd_data_out    = rd_data_reg;
	assign lb_active_out  = lb_active_reg;
	assign rd_valid_out   = rd_valid_reg;
	assign lb_start_out   = lb_start_reg;
	assign os_retry_out   = os_retry_reg;
	assign comm_fault_out = comm_fault_reg;
	assign drive_stop_out = comm_fault_reg;

	// helper state for the checks, port a only
	wire chk_msg_bad = rx_irq_in[0] & (~rx_marked_in[0] | ~rx_eof_in[0] | rx_crc_err_in[0]
		| rx_frame_err_in[0] | (rx_len_actual_in[0] != rx_len_field_in[0]));
	logic chk_prev_bad_reg;
	logic chk_ticked_reg;

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			chk_prev_bad_reg <= 1'b0;
			chk_ticked_reg   <= 1'b0;
		end else begin
			if (fault_reset_in)
				chk_prev_bad_reg <= 1'b0;
			else if (rx_irq_in[0])
				chk_prev_bad_reg <= chk_msg_bad;
			if (rx_irq_in[0])
				chk_ticked_reg <= 1'b0;
			else if (comm_cycle_tick_in[0])
				chk_ticked_reg <= 1'b1;
		end
	end

	// checks on port a
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	a_remote_sticky: assert property (
		rem_stat_reg[0][0] && !fault_reset_in && !warning_reset_in |=> rem_stat_reg[0][0])
		else $error("remote status bit dropped without reset");
	a_local_sticky: assert property (
		loc_stat_reg[0][BIT_OVERRUN] && !clr_stat ##1 !clr_stat |=> loc_stat_reg[0][BIT_OVERRUN])
		else $error("local status bit dropped without reset");
	a_unmarked_set: assert property (
		rx_irq_in[0] && !rx_marked_in[0] |=> loc_stat_reg[0][BIT_RX_UNMARKED])
		else $error("unmarked interrupt not latched");
	a_format_set: assert property (
		rx_irq_in[0] && (rx_len_actual_in[0] != rx_len_field_in[0])
		|=> loc_stat_reg[0][BIT_FORMAT] && fmt_cnt_reg[0] == $past(fmt_cnt_reg[0]) + COUNT_STEP)
		else $error("length mismatch not recorded");
	a_silent_ticks: assert property (
		comm_cycle_tick_in[0] && !rx_irq_in[0] && chk_ticked_reg
		|=> loc_stat_reg[0][BIT_SYNC_LOSS] && rem_stat_reg[0][BIT_REM_SYNC])
		else $error("silent ticks not flagged");
	a_gain_missed: assert property (
		gain_rx_in[0] && gain_mem_busy_in[0] |=> loc_stat_reg[0][BIT_MISSED_GAIN])
		else $error("missed gain not latched");
	a_rx_count_wrap: assert property (
		rx_irq_in[0] |=> rx_cnt_reg[0] == $past(rx_cnt_reg[0]) + COUNT_STEP)
		else $error("receive count did not step");
	a_download_retry: assert property (
		os_req_in[0] && !os_match_in[0] |=> os_retry_out[0] && loc_stat_reg[0][BIT_NO_OS_IMAGE])
		else $error("download failure without retry");
	a_two_errors: assert property (
		chk_msg_bad && chk_prev_bad_reg && !fault_reset_in
		|=> comm_fault_out[0] && drive_stop_out[0])
		else $error("two consecutive errors gave no fault");
	a_read_latency: assert property (
		rd_en_in && rd_addr_in == ADDR_RX_CNT_A
		|=> rd_valid_out && rd_data_out == $past(rx_cnt_reg[0]))
		else $error("read data wrong or late");
	a_no_eof_set: assert property (
		rx_irq_in[0] && !rx_eof_in[0] |=> loc_stat_reg[0][BIT_NO_EOF])
		else $error("missing end of frame not latched");
	a_crc_frame_set: assert property (
		rx_irq_in[0] && (rx_crc_err_in[0] || rx_frame_err_in[0]) |=> loc_stat_reg[0][BIT_CRC_FRAME])
		else $error("crc or framing error not latched");
	a_overrun_set: assert property (
		rx_overrun_in[0] |=> loc_stat_reg[0][BIT_OVERRUN])
		else $error("overrun not latched");
	a_underrun_set: assert property (
		tx_underrun_in[0] |=> loc_stat_reg[0][BIT_TX_UNDERRUN])
		else $error("underrun not latched");
	a_loopback_bad: assert property (
		lb_state_reg[0] == LB_WAIT && lb_done_in[0]
		&& lb_tx_word_in[0] != lb_rx_word_in[0] |=> loc_stat_reg[0][BIT_LOOPBACK])
		else $error("loopback mismatch not latched");
	a_loopback_once: assert property (
		!lb_active_out[0] |=> !lb_active_out[0] && !lb_start_out[0])
		else $error("loopback ran again without reset");
	a_start_pulse: assert property (
		lb_start_out[0] |=> !lb_start_out[0])
		else $error("loopback start longer than one cycle");
	a_mux_local: assert property (
		mux_fb_fail_in[0] |=> loc_stat_reg[0][BIT_MUX_VERIFY] && rem_stat_reg[0][BIT_REM_MUX])
		else $error("feedback verify failure not latched");
	a_mux_remote: assert property (
		mux_cmd_fail_in[0] |=> rem_stat_reg[0][BIT_REM_MUX])
		else $error("command verify failure not latched");
	a_header_set: assert property (
		os_hdr_invalid_in[0] |=> loc_stat_reg[0][BIT_BAD_OS_HDR] && os_retry_out[0])
		else $error("bad image header not latched");
	a_hw_incompat: assert property (
		os_hw_incompat_in[0] |=> loc_stat_reg[0][BIT_HW_INCOMPAT] && os_retry_out[0])
		else $error("incompatible hardware not latched");
	a_remote_report: assert property (
		rem_stat_valid_in[0]
		|=> (rem_stat_reg[0] & $past(rem_stat_word_in[0])) == $past(rem_stat_word_in[0]))
		else $error("remote report bits not latched");
	a_crc_count: assert property (
		rx_irq_in[0] && rx_crc_err_in[0]
		|=> crc_cnt_reg[0] == $past(crc_cnt_reg[0]) + COUNT_STEP)
		else $error("crc count did not step");
	a_rx_count_hold: assert property (
		!rx_irq_in[0] |=> rx_cnt_reg[0] == $past(rx_cnt_reg[0]))
		else $error("receive count moved without message");
	a_warning_clear: assert property (
		clr_stat && !rem_stat_valid_in[0] && !comm_cycle_tick_in[0]
		&& !mux_fb_fail_in[0] && !mux_cmd_fail_in[0] |=> rem_stat_reg[0] == STAT_RESET)
		else $error("remote status not cleared by reset");
	a_fault_clears: assert property (
		fault_reset_in && !rx_irq_in[0] && !comm_cycle_tick_in[0] |=> !comm_fault_out[0])
		else $error("comm fault not cleared by fault reset");
	a_fault_sticky: assert property (
		comm_fault_out[0] && !fault_reset_in |=> comm_fault_out[0])
		else $error("comm fault dropped without fault reset");
	a_drive_stop: assert property (
		drive_stop_out[0] == comm_fault_out[0])
		else $error("drive stop differs from comm fault");
	a_read_valid: assert property (
		rd_valid_out == $past(rd_en_in))
		else $error("read valid not one cycle after request");
	a_read_unmapped: assert property (
		rd_en_in && rd_addr_in == 11'h055 |=> rd_data_out == READ_ZERO)
		else $error("unmapped read not zero");
	a_retry_idle: assert property (
		!os_req_in[0] && !os_hdr_invalid_in[0] && !os_hw_incompat_in[0] |=> !os_retry_out[0])
		else $error("retry without download failure");

	// checks on port b
	a_rx_count_b: assert property (
		rx_irq_in[1] |=> rx_cnt_reg[1] == $past(rx_cnt_reg[1]) + COUNT_STEP)
		else $error("port b receive count did not step");
	a_crc_count_b: assert property (
		rx_irq_in[1] && rx_crc_err_in[1]
		|=> crc_cnt_reg[1] == $past(crc_cnt_reg[1]) + COUNT_STEP)
		else $error("port b crc count did not step");
	a_format_b: assert property (
		rx_irq_in[1] && (rx_len_actual_in[1] != rx_len_field_in[1])
		|=> fmt_cnt_reg[1] == $past(fmt_cnt_reg[1]) + COUNT_STEP)
		else $error("port b format count did not step");
	a_unmarked_b: assert property (
		rx_irq_in[1] && !rx_marked_in[1] |=> loc_stat_reg[1][BIT_RX_UNMARKED])
		else $error("port b unmarked interrupt not latched");
	a_mux_b: assert property (
		mux_cmd_fail_in[1] |=> rem_stat_reg[1][BIT_REM_MUX])
		else $error("port b verify failure not latched");
	a_overrun_b: assert property (
		rx_overrun_in[1] |=> loc_stat_reg[1][BIT_OVERRUN])
		else $error("port b overrun not latched");
	a_gain_missed_b: assert property (
		gain_rx_in[1] && gain_mem_busy_in[1] |=> loc_stat_reg[1][BIT_MISSED_GAIN])
		else $error("port b missed gain not latched");

endmodule // flsm_monitor
`default_nettype wire

// ===== bench/flsm_remote_model.sv
// remote power processor model feeding both receive ports
`timescale 1ns/1ps
`default_nettype none
module flsm_remote_model (
	// clock
	input  wire logic             clk_in,
	// receive events and reports toward the monitor
	output var  logic [1:0]       rx_irq_out,
	output var  logic [1:0]       rx_marked_out,
	output var  logic [1:0]       rx_eof_out,
	output var  logic [1:0]       rx_crc_err_out,
	output var  logic [1:0]       rx_frame_err_out,
	output var  logic [1:0][7:0]  rx_len_actual_out,
	output var  logic [1:0][7:0]  rx_len_field_out,
	output var  logic [1:0]       os_req_out,
	output var  logic [1:0]       os_match_out,
	output var  logic [1:0]       rem_stat_valid_out,
	output var  logic [1:0][15:0] rem_stat_word_out
);
	initial begin
		{rx_irq_out, rx_marked_out, rx_eof_out, rx_crc_err_out, rx_frame_err_out} = '0;
		{rx_len_actual_out, rx_len_field_out, os_req_out, os_match_out} = '0;
		{rem_stat_valid_out, rem_stat_word_out} = '0;
	end
	// burst of n messages; flags: marked, eof, crc, framing, length mismatch
	task automatic send(input int p, input int n, input logic [4:0] f);
		logic [7:0] len;
		len = 8'($urandom);
		@(posedge clk_in);
		rx_irq_out[p] <= 1'b1;
		{rx_marked_out[p], rx_eof_out[p], rx_crc_err_out[p], rx_frame_err_out[p]} <= f[4:1];
		rx_len_actual_out[p] <= len;
		rx_len_field_out[p] <= f[0] ? ~len : len;
		repeat (n) @(posedge clk_in);
		rx_irq_out[p] <= 1'b0;
		{rx_marked_out[p], rx_eof_out[p], rx_crc_err_out[p], rx_frame_err_out[p]} <= ~f[4:1];
		rx_len_field_out[p] <= f[0] ? len : ~len;
	endtask
	// image request, issued again by the caller after a failure
	task automatic os_request(input int p, input logic m);
		@(posedge clk_in);
		os_req_out[p] <= 1'b1;
		os_match_out[p] <= m;
		@(posedge clk_in);
		os_req_out[p] <= 1'b0;
		os_match_out[p] <= ~m;
	endtask
	// status report; bit 12 flags a bad image start address
	task automatic report(input int p, input logic [15:0] w);
		@(posedge clk_in);
		rem_stat_valid_out[p] <= 1'b1;
		rem_stat_word_out[p] <= w;
		@(posedge clk_in);
		rem_stat_valid_out[p] <= 1'b0;
		rem_stat_word_out[p] <= ~w;
	endtask
endmodule // flsm_remote_model
`default_nettype wire

// ===== bench/fiber_link_status_monitor_bench.sv
// self-checking bench for the fiber link status monitor
`timescale 1ns/1ps
`default_nettype none
module fiber_link_status_monitor_bench;
	import flsm_pkg::*;
	localparam int TK[8] = '{0, 1, 3, 3, 5, 6, 7, 8};
	localparam int TK2[8] = '{12, 12, 12, 4, 12, 12, 12, 12};
	localparam logic [15:0] TL[8] = '{16'h0008, 16'h0020, 16'h0000, 16'h0100,
		16'h0200, 16'h0000, 16'h0800, 16'h1000};
	logic             clk_in = 1'b0;
	logic             rst_n_in = 1'b0;
	logic [1:0]       ev [0:11];
	logic [1:0][15:0] lb_tx = '0, lb_rx = '0;
	logic             rd_en = 1'b0;
	logic [10:0]      rd_addr = '0;
	logic [15:0]      rd_data;
	logic             rd_valid;
	logic [1:0]       irq, mk, eof, crc, frm, osq, osm, rv, lbs, lba, retry, cf, ds, seen;
	logic [1:0][7:0]  la, lf;
	logic [1:0][15:0] rw;
	logic [15:0]      e_loc[2], e_rem[2], e_rx[2], e_crc[2], e_fmt[2];
	int               n_errors = 0, n_tests = 0, cyc = 0;
	flsm_monitor flsm_monitor_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.fault_reset_in(ev[10][0]), .warning_reset_in(ev[11][0]), .rx_irq_in(irq),
		.rx_marked_in(mk), .rx_eof_in(eof), .rx_crc_err_in(crc), .rx_frame_err_in(frm),
		.rx_len_actual_in(la), .rx_len_field_in(lf), .rx_overrun_in(ev[0]),
		.tx_underrun_in(ev[1]), .comm_cycle_tick_in(ev[2]), .lb_done_in(ev[9]),
		.lb_tx_word_in(lb_tx), .lb_rx_word_in(lb_rx), .gain_rx_in(ev[3]),
		.gain_mem_busy_in(ev[4]), .mux_fb_fail_in(ev[5]), .mux_cmd_fail_in(ev[6]),
		.os_req_in(osq), .os_match_in(osm), .os_hdr_invalid_in(ev[7]),
		.os_hw_incompat_in(ev[8]), .rem_stat_valid_in(rv), .rem_stat_word_in(rw),
		.rd_en_in(rd_en), .rd_addr_in(rd_addr), .rd_data_out(rd_data),
		.rd_valid_out(rd_valid), .lb_start_out(lbs), .lb_active_out(lba),
		.os_retry_out(retry), .comm_fault_out(cf), .drive_stop_out(ds));
	flsm_remote_model flsm_remote_model_inst (.clk_in(clk_in), .rx_irq_out(irq),
		.rx_marked_out(mk), .rx_eof_out(eof), .rx_crc_err_out(crc), .rx_frame_err_out(frm),
		.rx_len_actual_out(la), .rx_len_field_out(lf), .os_req_out(osq),
		.os_match_out(osm), .rem_stat_valid_out(rv), .rem_stat_word_out(rw));
	always #25 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 90000) begin
			n_errors++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rd(input logic [10:0] a, input logic [15:0] e);
		@(posedge clk_in);
		rd_en <= 1'b1;
		rd_addr <= a;
		@(posedge clk_in);
		rd_en <= 1'b0;
		#1;
		chk("read valid", 16'h0001, {15'h0, rd_valid});
		chk($sformatf("word at %h", a), e, rd_data);
	endtask
	task automatic chk_all();
		for (int p = 0; p < 2; p++) begin
			rd(p ? ADDR_LOC_STAT_B : ADDR_LOC_STAT_A, e_loc[p]);
			rd(p ? ADDR_RX_CNT_B : ADDR_RX_CNT_A, e_rx[p]);
			rd(p ? ADDR_CRC_CNT_B : ADDR_CRC_CNT_A, e_crc[p]);
			rd(p ? ADDR_FMT_CNT_B : ADDR_FMT_CNT_A, e_fmt[p]);
			rd(p ? ADDR_REM_STAT_B : ADDR_REM_STAT_A, e_rem[p]);
		end
	endtask
	task automatic pulse(input int k, input int p, input int k2 = 12);
		@(posedge clk_in);
		ev[k][p] <= 1'b1;
		if (k2 < 12) ev[k2][p] <= 1'b1;
		@(posedge clk_in);
		ev[k] <= 2'b00;
		if (k2 < 12) ev[k2] <= 2'b00;
	endtask
	task automatic clr(input int k);
		pulse(k, 0);
		e_loc = '{16'h0, 16'h0};
		e_rem = '{16'h0, 16'h0};
	endtask
	function automatic logic [15:0] msg_bits(input logic [4:0] f);
		return {11'h0, f[0], 1'b0, f[2] | f[1], ~f[3], ~f[4]};
	endfunction
	task automatic msg(input int p, input int n, input logic [4:0] f);
		flsm_remote_model_inst.send(p, n, f);
		e_loc[p] |= msg_bits(f);
		e_rx[p] += 16'(n);
		e_crc[p] += f[2] ? 16'(n) : 16'h0;
		e_fmt[p] += f[0] ? 16'(n) : 16'h0;
	endtask
	task automatic see_retry(input logic [1:0] e);
		#1 seen = retry;
		@(posedge clk_in);
		#1 seen |= retry;
		chk("retry", {14'h0, e}, {14'h0, seen});
	endtask
	initial begin
		foreach (ev[i]) ev[i] = 2'b00;
		clr(11);
		e_rx = '{16'h0, 16'h0};
		e_crc = e_rx;
		e_fmt = e_rx;
		void'($urandom(8674));
		repeat (20) @(posedge clk_in);
		rst_n_in <= 1'b1;
		seen = 2'b00;
		repeat (3) begin
			@(posedge clk_in);
			#1 seen |= lbs;
		end
		chk("loopback start", 16'h0003, {14'h0, seen});
		chk("loopback active", 16'h0003, {14'h0, lba});
		chk_all();
		rd(11'h055, READ_ZERO);
		rd(11'h437, READ_ZERO);
		@(posedge clk_in);
		lb_tx <= {16'h5A5A, 16'h1234};
		lb_rx <= {16'h5A5A, 16'h1235};
		pulse(9, 0);
		pulse(9, 1);
		e_loc[0] |= 16'h0080;
		#1;
		chk("loopback active", 16'h0000, {14'h0, lba});
		chk_all();
		clr(11);
		pulse(9, 0);
		chk_all();
		repeat (60) msg($urandom % 2, 1, 5'($urandom));
		msg(0, 3, 5'b11000);
		msg(1, 3, 5'b11000);
		chk_all();
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 8; i++) begin
				pulse(TK[i], p, TK2[i]);
				e_loc[p] |= TL[i];
				e_rem[p] |= (i == 4 || i == 5) ? 16'h0200 : 16'h0000;
				see_retry(i >= 6 ? 2'(1 << p) : 2'b00);
			end
			flsm_remote_model_inst.os_request(p, 1'b1);
			see_retry(2'b00);
			flsm_remote_model_inst.os_request(p, 1'b0);
			see_retry(2'(1 << p));
			flsm_remote_model_inst.os_request(p, 1'b0);
			e_loc[p] |= 16'h0400;
			flsm_remote_model_inst.report(p, 16'h1000);
			e_rem[p] |= 16'h1000;
		end
		chk_all();
		clr(11);
		msg(0, 1, 5'b11000);
		msg(1, 1, 5'b11000);
		pulse(2, 0);
		pulse(2, 1);
		chk_all();
		pulse(2, 0);
		pulse(2, 1);
		e_loc = '{16'h0040, 16'h0040};
		e_rem = '{16'h0100, 16'h0100};
		chk_all();
		clr(10);
		msg(0, 1, 5'b01000);
		repeat (3) @(posedge clk_in);
		#1 chk("fault after one", 16'h0000, {12'h0, cf, ds});
		msg(0, 1, 5'b01000);
		repeat (3) @(posedge clk_in);
		#1 chk("fault after two", 16'h0005, {12'h0, cf, ds});
		clr(10);
		repeat (2) @(posedge clk_in);
		#1 chk("fault cleared", 16'h0000, {12'h0, cf, ds});
		msg(1, 65540, 5'b10101);
		chk_all();
		wrap_up();
	end
endmodule // fiber_link_status_monitor_bench
`default_nettype wire
